// >>> usu_core.sv
`timescale 1ns/10ps
`include "usu_params.svh"
// Behaviour
// [R1] External clock counts on both pin edges
// [R2] Counter chains with compare-match timer
// [R3] Preset to F gives edge interrupt
// [R4] Data write beats simultaneous shift
// [R5] Shift left on selected clock source
// [R6] Inputs still work with outputs off
// [R7] Data pin driven from bit 7 via latch
// [R8] Latch open half-cycle external, always internal
// [R9] Open latch passes new top bit at once
// [R10] Data pin driven only when direction set
// [R11] Buffer copies shifter on transfer end
// [R12] Start flag: start condition or clock edge
// [R13] Start interrupt needs flag, enable, global
// [R14] Start flag cleared by one, releases hold
// [R15] Start interrupt wakes from any sleep
// [R16] Wrap flag at 15 to 0, interrupt, hold
// [R17] Wrap interrupt wakes from idle
// [R18] Stop flag in two-wire, no interrupt
// [R19] Mismatch bit: bit 7 versus pin
// [R20] Low status nibble is the counter
// [R21] Counter steps on selected clock source
// [R22] Toggle strobe clocks when strobe select set
// [R23] Wire mode zero disables outputs and holds
// [R24] Hold mode keeps clock low after wrap
// [R25] Zero writes keep flags; set beats clear
module usu_core
  import usu_pkg::*;
(
  input  wire logic       clk,         // System clock
  input  wire logic       rst,         // Synchronous reset
  input  wire logic [2:0] addr,        // Register index
  input  wire logic [7:0] wdata,       // Write data
  input  wire logic       wr,          // Write strobe
  input  wire logic       rd,          // Read strobe
  output logic      [7:0] rdata,       // Read data
  input  wire logic       global_ie,   // Global interrupt enable
  input  wire logic       timer_match, // Timer compare match pulse
  input  wire logic       sck_in,      // Serial clock pin level
  input  wire logic       sda_in,      // Serial data pin level
  input  wire logic       sck_ddr,     // Clock pin direction
  input  wire logic       sda_ddr,     // Data pin direction
  input  wire logic       dout_ddr,    // Three-wire output direction
  input  wire logic       sda_port,    // Data pin port bit
  output logic            sck_out,     // Clock pin value
  output logic            sck_oe_n,    // Clock pin enable, low drives
  output logic            sda_out,     // Data pin value
  output logic            sda_oe_n,    // Data pin enable, low drives
  output logic            dout,        // Three-wire data out
  output logic            dout_oe_n,   // Data out enable, low drives
  output logic            start_irq,   // Start interrupt
  output logic            wrap_irq,    // Wrap interrupt
  output logic            wake_all,    // Wake from any sleep
  output logic            wake_idle,   // Wake from idle
  output logic            wrap_tick    // Wrap pulse to timer
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic       sck_s1_q, sck_s2_q, sck_s3_q;
  logic       sda_s1_q, sda_s2_q, sda_s3_q;
  logic       sck_rise, sck_fall, sda_rise, sda_fall;

  // Two flops, then a history flop for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  assign sck_rise = sck_s2_q & ~sck_s3_q;
  assign sck_fall = ~sck_s2_q & sck_s3_q;
  assign sda_rise = sda_s2_q & ~sda_s3_q;
  assign sda_fall = ~sda_s2_q & sda_s3_q;

  // ****************************************
  // Register decode and control register
  // ****************************************
  logic       wr_ctrl, wr_data, wr_stat;
  logic       sie_q, oie_q, clkstb_q;
  usu_wmode_t wm_q;
  usu_csrc_t  cs_q;
  logic [1:0] cs_now;
  logic       clkstb_now, strobe_clk, strobe_tc;

  assign wr_ctrl = wr && (addr == `USU_OFS_CTRL);
  assign wr_data = wr && (addr == `USU_OFS_DATA);
  assign wr_stat = wr && (addr == `USU_OFS_STAT);

  // Strobes act with the source written alongside them
  assign cs_now     = wr_ctrl ? wdata[`USU_C_CS_HI:`USU_C_CS_LO] : cs_q;
  assign clkstb_now = wr_ctrl ? wdata[`USU_C_CLK] : clkstb_q;
  assign strobe_clk = wr_ctrl & wdata[`USU_C_CLK];
  assign strobe_tc  = wr_ctrl & wdata[`USU_C_TC];

  // Control fields
  always_ff @(posedge clk) begin
    if (rst) begin
      sie_q    <= 1'b0;
      oie_q    <= 1'b0;
      wm_q     <= USU_WM_OFF;
      cs_q     <= USU_CS_SOFT;
      clkstb_q <= 1'b0;
    end else if (wr_ctrl) begin
      sie_q    <= wdata[`USU_C_SIE];
      oie_q    <= wdata[`USU_C_OIE];
      wm_q     <= usu_wmode_t'(wdata[`USU_C_WM_HI:`USU_C_WM_LO]);
      cs_q     <= usu_csrc_t'(wdata[`USU_C_CS_HI:`USU_C_CS_LO]);
      clkstb_q <= wdata[`USU_C_CLK];
    end
  end

  // ****************************************
  // Clock source selection
  // ****************************************
  logic two_wire, tc_mode, count_tick, shift_tick;
  logic sck_tgl_q;

  assign two_wire = (wm_q == USU_WM_TWO) || (wm_q == USU_WM_TWO_HOLD);
  assign tc_mode  = cs_now[1] & clkstb_now; // R22

  // Software clock pin level, flipped by the toggle strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_tgl_q <= 1'b0;
    end else if (strobe_tc) begin
      sck_tgl_q <= ~sck_tgl_q; // R22
    end
  end

  // Counter and shifter ticks per source
  always_comb begin
    count_tick = 1'b0;
    shift_tick = 1'b0;
    unique case (cs_now)
      2'h0: begin
        count_tick = strobe_clk; // R21
        shift_tick = strobe_clk; // R5
      end
      2'h1: begin
        count_tick = timer_match; // R2
        shift_tick = timer_match; // R5
      end
      2'h2, 2'h3: begin
        if (tc_mode) begin
          count_tick = strobe_tc; // R22
          shift_tick = strobe_tc & (sck_tgl_q == cs_now[0]); // R22
        end else begin
          count_tick = sck_rise | sck_fall; // R1 R6
          shift_tick = cs_now[0] ? sck_fall : sck_rise; // R5 R6
        end
      end
    endcase
  end

  // ****************************************
  // Shift register, counter and buffer
  // ****************************************
  logic [7:0] data_q, data_d, buf_q;
  logic [3:0] cnt_q;
  logic       wrap;

  // Write wins over a shift in the same cycle
  always_comb begin
    if (wr_data) begin
      data_d = wdata; // R4
    end else if (shift_tick) begin
      data_d = {data_q[6:0], sda_s2_q}; // R5 R6
    end else begin
      data_d = data_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= `USU_RST_BYTE;
    end else begin
      data_q <= data_d;
    end
  end

  // Software write of the count beats a tick
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= `USU_RST_CNT;
    end else if (wr_stat) begin
      cnt_q <= wdata[`USU_S_CNT_HI:0]; // R20 R3
    end else if (count_tick) begin
      cnt_q <= cnt_q + 4'h1; // R21 R1
    end
  end

  assign wrap = count_tick & ~wr_stat & (cnt_q == `USU_CNT_MAX); // R16 R3

  // Transfer complete copies the shifter
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_q <= `USU_RST_BYTE;
    end else if (wrap) begin
      buf_q <= data_d; // R11
    end
  end

  // Wrap pulse feeds the timer for a wider count
  always_ff @(posedge clk) begin
    if (rst) begin
      wrap_tick <= 1'b0;
    end else begin
      wrap_tick <= wrap; // R2
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  logic sif_q, oif_q, pf_q, start_evt, stop_evt;
  logic clr_sif, clr_oif, clr_pf, mismatch;

  assign start_evt = (two_wire & sda_fall & sck_s2_q) // R12
                   | (~two_wire & cs_q[1] & ~clkstb_q
                      & (sck_rise | sck_fall)); // R12
  assign stop_evt  = two_wire & sda_rise & sck_s2_q; // R18
  assign clr_sif   = wr_stat & wdata[`USU_S_SIF]; // R14
  assign clr_oif   = wr_stat & wdata[`USU_S_OIF]; // R16
  assign clr_pf    = wr_stat & wdata[`USU_S_PF]; // R18
  assign mismatch  = data_q[7] ^ sda_s2_q; // R19

  // Set wins over a same-cycle clear; zero writes keep
  always_ff @(posedge clk) begin
    if (rst) begin
      sif_q <= 1'b0;
      oif_q <= 1'b0;
      pf_q  <= 1'b0;
    end else begin
      sif_q <= start_evt | (sif_q & ~clr_sif); // R12 R14 R25
      oif_q <= wrap | (oif_q & ~clr_oif); // R16 R25
      pf_q  <= stop_evt | (pf_q & ~clr_pf); // R18 R25
    end
  end

  // Interrupts and wake requests; stop flag feeds none
  always_ff @(posedge clk) begin
    if (rst) begin
      start_irq <= 1'b0;
      wrap_irq  <= 1'b0;
      wake_all  <= 1'b0;
      wake_idle <= 1'b0;
    end else begin
      start_irq <= sif_q & sie_q & global_ie; // R13
      wrap_irq  <= oif_q & oie_q & global_ie; // R16 R3
      wake_all  <= sif_q & sie_q; // R15
      wake_idle <= oif_q & oie_q; // R17
    end
  end

  // ****************************************
  // Output latch and clock holds
  // ****************************************
  logic lat_q, lat_open, hold_start_q, hold_wrap;

  // Open in first clock half for external, always else
  assign lat_open = ~cs_q[1] | (sck_s2_q == cs_q[0]); // R8

  always_ff @(posedge clk) begin
    if (rst) begin
      lat_q <= 1'b0;
    end else if (lat_open) begin
      lat_q <= data_d[7]; // R7 R9
    end
  end

  // Start hold begins at the clock fall after a start
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_start_q <= 1'b0;
    end else if (!sif_q || !two_wire) begin
      hold_start_q <= 1'b0; // R14 R23
    end else if (sck_fall) begin
      hold_start_q <= 1'b1;
    end
  end

  assign hold_wrap = oif_q & (wm_q == USU_WM_TWO_HOLD); // R24

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      dout      <= 1'b0;
      dout_oe_n <= 1'b1;
      sda_out   <= 1'b0;
      sda_oe_n  <= 1'b1;
      sck_out   <= 1'b0;
      sck_oe_n  <= 1'b1;
    end else begin
      dout      <= lat_q; // R7
      sda_out   <= 1'b0;
      dout_oe_n <= 1'b1;
      sda_oe_n  <= 1'b1;
      sck_out   <= 1'b0;
      sck_oe_n  <= 1'b1;
      unique case (wm_q)
        USU_WM_OFF: begin
          sck_out <= 1'b0; // R23
        end
        USU_WM_THREE: begin
          dout_oe_n <= ~dout_ddr; // R10
          sck_out   <= sck_tgl_q; // R22
          sck_oe_n  <= ~sck_ddr;
        end
        USU_WM_TWO, USU_WM_TWO_HOLD: begin
          sda_oe_n <= ~(sda_ddr & (~lat_q | ~sda_port)); // R10 R7
          sck_oe_n <= ~(sck_ddr & (~sck_tgl_q | hold_start_q
                                   | hold_wrap)); // R14 R24
        end
      endcase
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `USU_RST_BYTE;
    end else if (rd) begin
      unique case (addr)
        `USU_OFS_CTRL: rdata <= {sie_q, oie_q, wm_q, cs_q, 2'h0};
        `USU_OFS_DATA: rdata <= data_q;
        `USU_OFS_BUF:  rdata <= buf_q; // R11
        `USU_OFS_STAT: rdata <= {sif_q, oif_q, pf_q, mismatch,
                                 cnt_q}; // R19 R20
        default:       rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence wrap_seen;
    wrap ##1 oif_q;
  endsequence
  sequence two_wire_held;
    hold_wrap && sck_ddr && two_wire;
  endsequence
  write_wins_a: assert property ( // R4
    wr_data |=> data_q == $past(wdata))
    else $error("data write lost to shift");
  shift_left_a: assert property ( // R5
    shift_tick && !wr_data |=>
      data_q == {$past(data_q[6:0]), $past(sda_s2_q)})
    else $error("shift not left");
  both_edges_a: assert property ( // R1
    cs_now[1] && !tc_mode && (sck_rise || sck_fall) && !wr_stat
      |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("external edge not counted");
  wrap_buffer_a: assert property ( // R11
    wrap_seen |-> buf_q == data_q)
    else $error("buffer not loaded at wrap");
  start_irq_a: assert property ( // R13
    sif_q && sie_q && global_ie |=> start_irq)
    else $error("start interrupt missing");
  flag_keep_a: assert property ( // R25
    (oif_q && !clr_oif) [*2] |-> ##1 oif_q)
    else $error("wrap flag lost without clear");
  mode_off_a: assert property ( // R23
    wm_q == USU_WM_OFF |=> dout_oe_n && sda_oe_n && sck_oe_n)
    else $error("output driven in mode off");
  dir_gate_a: assert property ( // R10
    !dout_ddr && !sda_ddr |=> dout_oe_n && sda_oe_n)
    else $error("data pin driven without direction");
  wrap_hold_a: assert property ( // R24
    two_wire_held |=> !sck_oe_n && !sck_out)
    else $error("clock not held after wrap");
  stop_quiet_a: assert property ( // R18
    stop_evt && !sif_q && !oif_q && !wrap
      |=> ##1 !start_irq && !wrap_irq)
    else $error("stop flag raised interrupt");

endmodule

// >>> usu_params.svh
`ifndef USU_PARAMS_SVH
`define USU_PARAMS_SVH

// ****************************************
// Register offsets (index on the plain port)
// ****************************************
`define USU_OFS_CTRL  3'h0
`define USU_OFS_DATA  3'h1
`define USU_OFS_BUF   3'h2
`define USU_OFS_STAT  3'h3

// ****************************************
// Control register fields
// ****************************************
`define USU_C_SIE     7
`define USU_C_OIE     6
`define USU_C_WM_HI   5
`define USU_C_WM_LO   4
`define USU_C_CS_HI   3
`define USU_C_CS_LO   2
`define USU_C_CLK     1
`define USU_C_TC      0

// ****************************************
// Status register fields
// ****************************************
`define USU_S_SIF     7
`define USU_S_OIF     6
`define USU_S_PF      5
`define USU_S_DC      4
`define USU_S_CNT_HI  3

// ****************************************
// Reset values and counts
// ****************************************
`define USU_RST_BYTE  8'h00
`define USU_RST_CNT   4'h0
`define USU_CNT_MAX   4'hf

`endif

// >>> usu_pkg.sv
package usu_pkg;
  // Wire mode, as held in the control register
  typedef enum logic [1:0] {
    USU_WM_OFF,
    USU_WM_THREE,
    USU_WM_TWO,
    USU_WM_TWO_HOLD
  } usu_wmode_t;

  // Clock source select
  typedef enum logic [1:0] {
    USU_CS_SOFT,
    USU_CS_TIMER,
    USU_CS_EXT_RISE,
    USU_CS_EXT_FALL
  } usu_csrc_t;
endpackage

// >>> usu_peer.sv
`timescale 1ns/10ps
// ****************************************
// Far side: serial master on clock and data
// ****************************************
module usu_peer (
  output logic sck, // Clock pin level
  output logic sda  // Data pin level
);
  // Lines idle high through pull-ups
  initial begin
    sck = 1'b1;
    sda = 1'b1;
  end

  // One bit: clock falls, data set, clock rises, data released
  task automatic send_bit(input logic b);
    #2; // Off the system clock edge
    sck = 1'b0;
    #40;
    sda = b;
    #40;
    sck = 1'b1;
    #40;
    sda = 1'b1;
    #40;
  endtask

  // Start then stop, clock held high throughout
  task automatic start_stop();
    #2; // Off the system clock edge
    sda = 1'b0;
    #80;
    sda = 1'b1;
    #80;
  endtask
endmodule

// >>> usu_core_bench.sv
`timescale 1ns/10ps
`include "usu_params.svh"
// ****************************************
// Bench for the serial shift and count core
// ****************************************
module usu_core_bench;
  logic       clk;
  logic       rst;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       global_ie;
  logic       timer_match;
  logic       dout_ddr;
  logic       sck_pin;
  logic       sda_pin;
  logic       dout;
  logic       dout_oe_n;
  logic       wrap_irq;
  logic       sck_ddr;
  logic       sda_ddr;
  logic       sda_port;
  logic       sck_out;
  logic       sck_oe_n;
  logic       sda_out;
  logic       sda_oe_n;
  logic       start_irq;
  logic       wake_all;
  logic       wake_idle;
  logic       wrap_tick;
  int         err_count;
  int         n_tests;
  int         cyc;

  usu_core usu_core_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .global_ie(global_ie),
    .timer_match(timer_match), .sck_in(sck_pin), .sda_in(sda_pin),
    .sck_ddr(sck_ddr), .sda_ddr(sda_ddr), .dout_ddr(dout_ddr),
    .sda_port(sda_port), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .dout(dout),
    .dout_oe_n(dout_oe_n), .start_irq(start_irq), .wrap_irq(wrap_irq),
    .wake_all(wake_all), .wake_idle(wake_idle), .wrap_tick(wrap_tick)
  );

  usu_peer usu_peer_inst (
    .sck(sck_pin),
    .sda(sda_pin)
  );

  // Clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      test_done();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    check(rdata & m, exp);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(`USU_OFS_CTRL, 8'hff, 8'h00);
    rd_chk(`USU_OFS_DATA, 8'hff, 8'h00);
    rd_chk(`USU_OFS_BUF, 8'hff, 8'h00);
    rd_chk(`USU_OFS_STAT, 8'hef, 8'h00);
    rd_chk(3'h5, 8'hff, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_soft_shift();
    wr_reg(`USU_OFS_CTRL, 8'h00);
    wr_reg(`USU_OFS_DATA, 8'h81);
    wr_reg(`USU_OFS_CTRL, 8'h02);
    rd_chk(`USU_OFS_DATA, 8'hff, 8'h03);
    rd_chk(`USU_OFS_STAT, 8'h0f, 8'h01);
    check({7'h0, dout_oe_n}, 8'h01);
    wr_reg(`USU_OFS_CTRL, 8'h04);
    @(posedge clk);
    addr        <= `USU_OFS_DATA;
    wdata       <= 8'h3c;
    wr          <= 1'b1;
    timer_match <= 1'b1;
    @(posedge clk);
    wr          <= 1'b0;
    timer_match <= 1'b0;
    rd_chk(`USU_OFS_DATA, 8'hff, 8'h3c);
    $display("test soft shift done");
  endtask

  task automatic t_wrap();
    global_ie <= 1'b1;
    wr_reg(`USU_OFS_STAT, 8'hef);
    wr_reg(`USU_OFS_DATA, 8'h40);
    wr_reg(`USU_OFS_CTRL, 8'h42);
    rd_chk(`USU_OFS_BUF, 8'hff, 8'h81);
    rd_chk(`USU_OFS_STAT, 8'hef, 8'h40);
    check({7'h0, wrap_irq}, 8'h01);
    wr_reg(`USU_OFS_STAT, 8'h00);
    rd_chk(`USU_OFS_STAT, 8'hef, 8'h40);
    wr_reg(`USU_OFS_STAT, 8'h40);
    rd_chk(`USU_OFS_STAT, 8'hef, 8'h00);
    $display("test wrap done");
  endtask

  task automatic t_ext_clock();
    wr_reg(`USU_OFS_CTRL, 8'h48);
    wr_reg(`USU_OFS_STAT, 8'hef);
    usu_peer_inst.send_bit(1'b1);
    usu_peer_inst.send_bit(1'b0);
    repeat (8) @(posedge clk);
    rd_chk(`USU_OFS_STAT, 8'hef, 8'hc3);
    rd_chk(`USU_OFS_DATA, 8'hff, 8'h06);
    rd_chk(`USU_OFS_BUF, 8'hff, 8'h81);
    $display("test external clock done");
  endtask

  task automatic t_two_wire();
    wr_reg(`USU_OFS_CTRL, 8'h28);
    wr_reg(`USU_OFS_STAT, 8'he0);
    usu_peer_inst.start_stop();
    repeat (8) @(posedge clk);
    rd_chk(`USU_OFS_STAT, 8'hef, 8'ha0);
    wr_reg(`USU_OFS_STAT, 8'ha0);
    rd_chk(`USU_OFS_STAT, 8'hef, 8'h00);
    $display("test two wire done");
  endtask

  task automatic t_three_wire();
    dout_ddr <= 1'b1;
    wr_reg(`USU_OFS_CTRL, 8'h10);
    wr_reg(`USU_OFS_STAT, 8'he0);
    wr_reg(`USU_OFS_DATA, 8'ha5);
    repeat (3) @(posedge clk);
    check({6'h0, dout, dout_oe_n}, 8'h02);
    wr_reg(`USU_OFS_DATA, 8'h25);
    repeat (3) @(posedge clk);
    check({7'h0, dout}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr_reg(`USU_OFS_CTRL, 8'h1b);
    end
    rd_chk(`USU_OFS_STAT, 8'hef, 8'h40);
    rd_chk(`USU_OFS_DATA, 8'hff, 8'hff);
    $display("test three wire done");
  endtask

  task automatic t_hold();
    sck_ddr <= 1'b1;
    sda_ddr <= 1'b1;
    wr_reg(`USU_OFS_STAT, 8'hef);
    wr_reg(`USU_OFS_CTRL, 8'h31);
    repeat (2) @(negedge clk);
    check({6'h0, sck_out, sck_oe_n}, 8'h01);
    wr_reg(`USU_OFS_CTRL, 8'h72);
    @(negedge clk);
    check({4'h0, wrap_tick, wake_idle, sck_out, sck_oe_n}, 8'h09);
    @(negedge clk);
    check({4'h0, wrap_tick, wake_idle, sck_out, sck_oe_n}, 8'h04);
    wr_reg(`USU_OFS_STAT, 8'h40);
    repeat (2) @(negedge clk);
    check({6'h0, wake_idle, sck_oe_n}, 8'h01);
    wr_reg(`USU_OFS_DATA, 8'h7f);
    repeat (2) @(negedge clk);
    check({6'h0, sda_out, sda_oe_n}, 8'h00);
    rd_chk(`USU_OFS_STAT, 8'h10, 8'h10);
    wr_reg(`USU_OFS_DATA, 8'h80);
    repeat (2) @(negedge clk);
    check({7'h0, sda_oe_n}, 8'h01);
    @(posedge clk);
    sda_port <= 1'b0;
    repeat (2) @(negedge clk);
    check({7'h0, sda_oe_n}, 8'h00);
    wr_reg(`USU_OFS_CTRL, 8'hf0);
    usu_peer_inst.start_stop();
    repeat (8) @(negedge clk);
    check({6'h0, start_irq, wake_all}, 8'h03);
    wr_reg(`USU_OFS_STAT, 8'ha0);
    repeat (2) @(negedge clk);
    check({6'h0, start_irq, wake_all}, 8'h00);
    $display("test hold done");
  endtask

  // Main sequence
  initial begin
    rst         = 1'b1;
    addr        = 3'h0;
    wdata       = 8'h00;
    wr          = 1'b0;
    rd          = 1'b0;
    global_ie   = 1'b0;
    timer_match = 1'b0;
    dout_ddr    = 1'b0;
    sck_ddr     = 1'b0;
    sda_ddr     = 1'b0;
    sda_port    = 1'b1;
    err_count   = 0;
    n_tests     = 0;
    cyc         = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_soft_shift();
    t_wrap();
    t_ext_clock();
    t_two_wire();
    t_three_wire();
    t_hold();
    test_done();
  end
endmodule
